// File: sdal_device.sv
// Device end: serial debug acquisition, command decode, protection and lock
`timescale 1ns/1ps
module sdal_device #(
  parameter int NBLK  = 16,
  parameter int BLK_W = 4
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  sdal_link_if.dev                       link,
  input  wire logic [sdal_pkg::KEY_W-1:0] lock_latch_nv_q,
  input  wire logic                      jtag_swd_on,
  output logic                           lock_latch_prog_req,
  output logic [sdal_pkg::KEY_W-1:0]     lock_latch_prog_data,
  output logic                           flash_req,
  output logic [1:0]                     flash_op,
  output logic [31:0]                    flash_data,
  output logic                           jtag_en,
  output logic                           swd_on_jtag,
  output logic                           swd_on_usb,
  output logic                           trace_single_en,
  output logic [sdal_pkg::PAR_TRACE_PINS-1:0] trace_par_oe,
  output logic                           locked,
  output logic                           acq_window
);

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RX  = 2'b01,
    ST_TX  = 2'b10
  } sdal_dst_t;

  sdal_dst_t                          st_r;
  logic [3:0]                         s1_r;
  logic [3:0]                         s2_r;
  logic [1:0]                         clk_prev_r;
  logic                               sampled_r;
  logic                               locked_r;
  logic [sdal_pkg::WIN_W-1:0]         win_cnt_r;
  logic [1:0][sdal_pkg::ACQ_LEN-1:0]  acq_sh_r;
  logic                               usb_sel_r;
  logic [sdal_pkg::CNT_W-1:0]         cnt_r;
  logic [sdal_pkg::FRAME_BITS-1:0]    rx_sh_r;
  logic [sdal_pkg::RSP_BITS-1:0]      rsp_r;
  logic                               drv_r;
  logic                               dout_r;
  logic                               off_pend_r;
  logic [sdal_pkg::KEY_W-1:0]         latch_vol_r;
  logic                               latch_prog_req_r;
  logic [sdal_pkg::KEY_W-1:0]         latch_prog_data_r;
  logic                               flash_req_r;
  logic [1:0]                         flash_op_r;
  logic [31:0]                        flash_data_r;
  logic [NBLK-1:0]                    prot_r;
  logic                               jtag_en_r;
  logic [1:0]                         trace_r;
  logic [sdal_pkg::KEY_W-1:0]         match_v;
  logic [5:0]                         match_cnt;

  wire [3:0] raw = {link.dio[1], link.clk[1], link.dio[0], link.clk[0]};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= raw[g];
          s2_r[g] <= s1_r[g];
        end
      end
    end
  endgenerate

  wire [1:0] pclk = {s2_r[2], s2_r[0]};
  wire [1:0] pdat = {s2_r[3], s2_r[1]};
  wire [1:0] rise = pclk & ~clk_prev_r;
  wire [1:0] fall = ~pclk & clk_prev_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_r <= 2'b00;
    end else begin
      clk_prev_r <= pclk;
    end
  end

  // Lock word compare, bit by bit
  generate
    for (g = 0; g < sdal_pkg::KEY_W; g++) begin : g_match
      assign match_v[g] = lock_latch_nv_q[g] ~^ sdal_pkg::LOCK_KEY[g];
    end
  endgenerate

  always_comb begin
    match_cnt = 6'h00;
    for (int i = 0; i < sdal_pkg::KEY_W; i++) begin
      match_cnt = match_cnt + 6'(match_v[i]);
    end
  end

  wire latch_match = match_cnt >= 6'(sdal_pkg::LOCK_MATCH_MIN);

  // Locked during reset; cells are read once after release only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sampled_r <= 1'b0;
      locked_r  <= sdal_pkg::LOCK_RST;
    end else if (!sampled_r) begin
      sampled_r <= 1'b1;
      locked_r  <= latch_match;
    end
  end

  wire win_open = sampled_r & ~locked_r &
                  (win_cnt_r < sdal_pkg::WIN_W'(sdal_pkg::KEY_WINDOW_CYC));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_r <= '0;
    end else if (sampled_r && win_open) begin
      win_cnt_r <= win_cnt_r + 1'b1;
    end
  end

  // Both pairs listen for the pattern; the JTAG pair wins a tie
  logic [1:0] acq_hit;
  generate
    for (g = 0; g < 2; g++) begin : g_acq
      wire [sdal_pkg::ACQ_LEN-1:0] acq_nxt = {pdat[g], acq_sh_r[g][sdal_pkg::ACQ_LEN-1:1]};
      assign acq_hit[g] = rise[g] & win_open & (st_r == ST_OFF) &
                          (acq_nxt == sdal_pkg::ACQ_SEQ);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          acq_sh_r[g] <= '0;
        end else if (rise[g]) begin
          acq_sh_r[g] <= acq_nxt;
        end
      end
    end
  endgenerate

  wire from_jtag = jtag_swd_on & jtag_en_r & ~locked_r & sampled_r;
  wire take_j    = (st_r == ST_OFF) & (acq_hit[0] | from_jtag);
  wire take_u    = (st_r == ST_OFF) & acq_hit[1] & ~take_j;

  wire srise = usb_sel_r ? rise[1] : rise[0];
  wire sfall = usb_sel_r ? fall[1] : fall[0];
  wire sdat  = usb_sel_r ? pdat[1] : pdat[0];

  wire [sdal_pkg::FRAME_BITS-1:0] rx_word = {sdat, rx_sh_r[sdal_pkg::FRAME_BITS-1:1]};
  wire last_rx = (st_r == ST_RX) & srise &
                 (cnt_r == sdal_pkg::CNT_W'(sdal_pkg::FRAME_BITS - 1));
  wire [7:0]       op  = rx_word[sdal_pkg::CMD_W-1:0];
  wire [31:0]      dat = rx_word[sdal_pkg::FRAME_BITS-1:sdal_pkg::CMD_W];
  wire [BLK_W-1:0] blk = dat[BLK_W-1:0];
  wire prot_any = |prot_r;

  // No scan chain or chaining operations exist in this command set
  wire is_load  = op == sdal_pkg::OP_LATCH_LOAD;
  wire is_prog  = op == sdal_pkg::OP_LATCH_PROG;
  wire is_read  = op == sdal_pkg::OP_LATCH_READ;
  wire is_erase = op == sdal_pkg::OP_ERASE_ALL;
  wire is_blk   = (op == sdal_pkg::OP_BLK_ERASE) | (op == sdal_pkg::OP_BLK_PROG) |
                  (op == sdal_pkg::OP_BLK_VERIFY);
  wire is_setp  = op == sdal_pkg::OP_SET_PROT;
  wire is_jen   = op == sdal_pkg::OP_JTAG_EN;
  wire is_off   = op == sdal_pkg::OP_SWD_OFF;
  wire is_trace = op == sdal_pkg::OP_TRACE_CFG;
  wire is_stat  = op == sdal_pkg::OP_STATUS;

  wire acc_load  = is_load & ~prot_any & ~locked_r;
  wire acc_prog  = is_prog & ~locked_r;
  wire acc_blk   = is_blk & ~prot_r[blk];
  wire acc_jen   = is_jen & (trace_r != sdal_pkg::TR_SINGLE);
  wire acc_trace = is_trace & (dat[1:0] != 2'b11) &
                   ~((dat[1:0] == sdal_pkg::TR_SINGLE) & jtag_en_r);
  wire accepted  = acc_load | acc_prog | acc_blk | acc_jen | acc_trace | is_erase |
                   is_setp | is_off | is_read | is_stat;

  wire [31:0] status_w = {26'h000_0000, trace_r, usb_sel_r, prot_any, jtag_en_r, accepted};
  wire [31:0] rsp_nxt  = is_read ? lock_latch_nv_q : status_w;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r       <= ST_OFF;
      usb_sel_r  <= 1'b0;
      cnt_r      <= '0;
      rx_sh_r    <= '0;
      rsp_r      <= '0;
      drv_r      <= 1'b0;
      dout_r     <= 1'b0;
      off_pend_r <= 1'b0;
    end else begin
      case (st_r)
        ST_OFF: begin
          if (take_j || take_u) begin
            st_r      <= ST_RX;
            usb_sel_r <= take_u;
            cnt_r     <= '0;
          end
        end
        ST_RX: begin
          if (srise) begin
            rx_sh_r <= rx_word;
            cnt_r   <= cnt_r + 1'b1;
          end
          if (last_rx) begin
            st_r       <= ST_TX;
            cnt_r      <= '0;
            rsp_r      <= rsp_nxt;
            off_pend_r <= is_off;
          end
        end
        ST_TX: begin
          if (srise) begin
            cnt_r <= cnt_r + 1'b1;
          end
          if (sfall) begin
            if (cnt_r == sdal_pkg::CNT_W'(sdal_pkg::RSP_BITS)) begin
              drv_r <= 1'b0;
              cnt_r <= '0;
              st_r  <= off_pend_r ? ST_OFF : ST_RX;
            end else begin
              drv_r  <= 1'b1;
              dout_r <= rsp_r[cnt_r[4:0]];
            end
          end
        end
        default: begin
          st_r <= ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_vol_r       <= '0;
      latch_prog_req_r  <= 1'b0;
      latch_prog_data_r <= '0;
      flash_req_r     <= 1'b0;
      flash_op_r      <= 2'b00;
      flash_data_r    <= '0;
      prot_r          <= '0;
      jtag_en_r       <= sdal_pkg::JTAG_EN_RST;
      trace_r         <= sdal_pkg::TR_NONE;
    end else begin
      latch_prog_req_r <= last_rx & acc_prog;
      flash_req_r    <= last_rx & (acc_blk | is_erase);
      if (last_rx && acc_load) begin
        latch_vol_r <= dat;
      end
      if (last_rx && acc_prog) begin
        latch_prog_data_r <= latch_vol_r;
      end
      if (last_rx && (acc_blk || is_erase)) begin
        flash_op_r   <= op[1:0];
        flash_data_r <= dat;
      end
      if (last_rx && is_erase) begin
        prot_r <= '0;
      end else if (last_rx && is_setp) begin
        prot_r <= prot_r | (NBLK'(1) << blk);
      end
      if (take_j) begin
        jtag_en_r <= 1'b0;
      end else if (last_rx && acc_jen) begin
        jtag_en_r <= 1'b1;
      end
      if (last_rx && acc_trace) begin
        trace_r <= dat[1:0];
      end
    end
  end

  assign link.d_do      = {dout_r, dout_r};
  assign link.d_oe      = {drv_r & usb_sel_r, drv_r & ~usb_sel_r};
  assign lock_latch_prog_req  = latch_prog_req_r;
  assign lock_latch_prog_data = latch_prog_data_r;
  assign flash_req      = flash_req_r;
  assign flash_op       = flash_op_r;
  assign flash_data     = flash_data_r;
  assign jtag_en        = jtag_en_r & ~locked_r;
  assign swd_on_jtag    = (st_r != ST_OFF) & ~usb_sel_r;
  assign swd_on_usb     = (st_r != ST_OFF) & usb_sel_r;
  assign trace_single_en = (trace_r == sdal_pkg::TR_SINGLE) & ~locked_r;
  assign trace_par_oe   = {sdal_pkg::PAR_TRACE_PINS{(trace_r == sdal_pkg::TR_PAR) & ~locked_r}};
  assign locked         = locked_r;
  assign acq_window     = win_open;

endmodule

// File: sdal_host.sv
// Host end: drives serial clock, sends acquisition and command frames
`timescale 1ns/1ps
module sdal_host #(
  parameter int HALF = sdal_pkg::SWCLK_HALF_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  sdal_link_if.host        link,
  input  wire logic        acq_start,
  input  wire logic        acq_usb,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_op,
  input  wire logic [31:0] cmd_data,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_data
);

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_ACQ  = 2'b01,
    H_TX   = 2'b10,
    H_RX   = 2'b11
  } sdal_hst_t;

  sdal_hst_t                        st_r;
  logic [7:0]                       div_r;
  logic                             sck_r;
  logic                             usb_r;
  logic                             oe_r;
  logic                             do_r;
  logic [sdal_pkg::CNT_W-1:0]       cnt_r;
  logic [sdal_pkg::FRAME_BITS-1:0]  tx_r;
  logic [31:0]                      rx_r;
  logic                             rsp_valid_r;
  logic [31:0]                      rsp_data_r;
  logic [1:0]                       s1_r;
  logic [1:0]                       s2_r;

  // Full period of 2*HALF core cycles stays within the one-third limit
  wire tick  = (st_r != H_IDLE) & (div_r == 8'(HALF - 1));
  wire hrise = tick & ~sck_r;
  wire hfall = tick & sck_r;
  wire din   = usb_r ? s2_r[1] : s2_r[0];
  wire start_cmd = (st_r == H_IDLE) & ~acq_start & cmd_valid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 2'b11;
      s2_r <= 2'b11;
    end else begin
      s1_r <= link.dio;
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 8'h00;
      sck_r <= 1'b0;
    end else if (st_r == H_IDLE) begin
      div_r <= 8'h00;
      sck_r <= 1'b0;
    end else if (tick) begin
      div_r <= 8'h00;
      sck_r <= ~sck_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r        <= H_IDLE;
      usb_r       <= 1'b0;
      oe_r        <= 1'b0;
      do_r        <= 1'b0;
      cnt_r       <= '0;
      tx_r        <= '0;
      rx_r        <= '0;
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= '0;
    end else begin
      rsp_valid_r <= 1'b0;
      case (st_r)
        H_IDLE: begin
          cnt_r <= '0;
          if (acq_start) begin
            st_r  <= H_ACQ;
            usb_r <= acq_usb;
            oe_r  <= 1'b1;
            do_r  <= sdal_pkg::ACQ_SEQ[0];
          end else if (start_cmd) begin
            st_r <= H_TX;
            tx_r <= {cmd_data, cmd_op};
            oe_r <= 1'b1;
            do_r <= cmd_op[0];
          end
        end
        H_ACQ: begin
          if (hrise) begin
            cnt_r <= cnt_r + 1'b1;
          end
          if (hfall) begin
            if (cnt_r == sdal_pkg::CNT_W'(sdal_pkg::ACQ_LEN)) begin
              st_r <= H_IDLE;
              oe_r <= 1'b0;
            end else begin
              do_r <= sdal_pkg::ACQ_SEQ[cnt_r[3:0]];
            end
          end
        end
        H_TX: begin
          if (hrise) begin
            cnt_r <= cnt_r + 1'b1;
          end
          if (hfall) begin
            if (cnt_r == sdal_pkg::CNT_W'(sdal_pkg::FRAME_BITS)) begin
              st_r  <= H_RX;
              oe_r  <= 1'b0;
              cnt_r <= '0;
            end else begin
              do_r <= tx_r[cnt_r];
            end
          end
        end
        H_RX: begin
          if (hrise) begin
            rx_r[cnt_r[4:0]] <= din;
            cnt_r            <= cnt_r + 1'b1;
          end
          if (hfall && cnt_r == sdal_pkg::CNT_W'(sdal_pkg::RSP_BITS)) begin
            st_r        <= H_IDLE;
            rsp_valid_r <= 1'b1;
            rsp_data_r  <= rx_r;
          end
        end
        default: begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  assign link.clk  = {sck_r & usb_r, sck_r & ~usb_r};
  assign link.h_do = {do_r, do_r};
  assign link.h_oe = {oe_r & usb_r, oe_r & ~usb_r};
  assign cmd_ready = (st_r == H_IDLE) & ~acq_start;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data  = rsp_data_r;

endmodule

// File: sdal_link_if.sv
// Two pin pairs between debug host and device, index 0 JTAG pair, 1 USB pair
`timescale 1ns/1ps
interface sdal_link_if;
  logic      [1:0] clk;
  logic      [1:0] h_do;
  logic      [1:0] h_oe;
  logic      [1:0] d_do;
  logic      [1:0] d_oe;
  wire logic [1:0] dio;

  // Weak pull-up when nobody drives; host wins a momentary overlap
  assign dio = (h_oe & h_do) | (~h_oe & d_oe & d_do) | (~h_oe & ~d_oe);

  modport dev  (input clk, input dio, output d_do, output d_oe);
  modport host (output clk, output h_do, output h_oe, input dio);
endinterface

// File: sdal_pkg.sv
// Shared constants and types for the serial debug acquire and lock block
package sdal_pkg;

  localparam int CLK_MHZ        = 100;
  localparam int KEY_WINDOW_NS  = 8000;
  // Longest time, so the cycle count rounds down
  localparam int KEY_WINDOW_CYC = (KEY_WINDOW_NS * CLK_MHZ) / 1000;
  localparam int WIN_W          = $clog2(KEY_WINDOW_CYC + 1);

  // Serial clock may run at most one third of the core clock
  localparam int SWCLK_MIN_DIV  = 3;
  // Eight cycles per half period also covers both synchroniser delays
  localparam int SWCLK_HALF_DEF = 8;

  localparam int ACQ_LEN = 16;
  // Arbitrary acquisition pattern, sent least significant bit first
  localparam logic [ACQ_LEN-1:0] ACQ_SEQ = 16'hA5C3;

  localparam int KEY_W          = 32;
  // Arbitrary lock key value
  localparam logic [KEY_W-1:0] LOCK_KEY = 32'h3C96_A55A;
  localparam int LOCK_MATCH_MIN = 28;

  localparam int CMD_W       = 8;
  localparam int FRAME_BITS  = 40;
  localparam int RSP_BITS    = 32;
  localparam int CNT_W       = 6;
  localparam int PAIR_JTAG   = 0;
  localparam int PAIR_USB    = 1;
  localparam int PAR_TRACE_PINS = 5;

  localparam logic JTAG_EN_RST = 1'b1;
  localparam logic LOCK_RST    = 1'b1;

  typedef enum logic [7:0] {
    OP_LATCH_LOAD = 8'h01,
    OP_LATCH_PROG = 8'h02,
    OP_LATCH_READ = 8'h03,
    OP_ERASE_ALL  = 8'h10,
    OP_BLK_ERASE  = 8'h11,
    OP_BLK_PROG   = 8'h12,
    OP_BLK_VERIFY = 8'h13,
    OP_SET_PROT   = 8'h14,
    OP_JTAG_EN    = 8'h20,
    OP_SWD_OFF    = 8'h21,
    OP_TRACE_CFG  = 8'h22,
    OP_STATUS     = 8'h30
  } sdal_op_t;

  typedef enum logic [1:0] {
    TR_NONE   = 2'b00,
    TR_SINGLE = 2'b01,
    TR_PAR    = 2'b10
  } sdal_trace_t;

endpackage

// File: sdal_props.sv
// Concurrent checks on the link of both ends and the status outputs of the device end
`timescale 1ns/1ps
module sdal_props (
  input wire logic                                clk,
  input wire logic                                rst_n,
  input wire logic [1:0]                          lclk,
  input wire logic [1:0]                          d_oe,
  input wire logic                                swd_on_jtag,
  input wire logic                                swd_on_usb,
  input wire logic                                jtag_en,
  input wire logic                                locked,
  input wire logic                                acq_window,
  input wire logic                                trace_single_en,
  input wire logic [sdal_pkg::PAR_TRACE_PINS-1:0] trace_par_oe,
  input wire logic                                flash_req
);
  localparam int WIN_CYC = sdal_pkg::KEY_WINDOW_CYC;
  logic [11:0] win_cnt_r;
  logic [11:0] win_cnt_nxt;
  logic        win_done_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  assign win_cnt_nxt = acq_window ? win_cnt_r + 12'h001 : 12'h000;

  // Sticky flag: once the window has closed it must stay shut until reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_r  <= 12'h000;
      win_done_r <= 1'b0;
    end else begin
      win_cnt_r  <= win_cnt_nxt;
      win_done_r <= win_done_r | (win_cnt_r != 12'h000 && !acq_window);
    end
  end

  sequence s_usb_start;
    $rose(swd_on_usb);
  endsequence

  sequence s_clk_held;
    lclk[0] [*3];
  endsequence

  a_one_pair_only: assert property (!(swd_on_jtag && swd_on_usb))
    else $error("serial debug active on both pairs");
  a_jtag_drive_sess: assert property (d_oe[0] |-> swd_on_jtag)
    else $error("device drives jtag pair without session");
  a_usb_drive_sess: assert property (d_oe[1] |-> swd_on_usb)
    else $error("device drives usb pair without session");
  a_lock_shuts_all: assert property (
      locked |-> !(jtag_en || swd_on_jtag || swd_on_usb || acq_window))
    else $error("port open while locked");
  a_lock_no_flash: assert property (locked |-> !flash_req)
    else $error("flash operation while locked");
  a_window_bound: assert property (acq_window |-> win_cnt_r < WIN_CYC)
    else $error("key window open too long");
  a_window_once: assert property (win_done_r |-> !acq_window)
    else $error("key window reopened without reset");
  a_usb_in_window: assert property (s_usb_start |-> $past(acq_window))
    else $error("usb session started outside key window");
  a_single_no_jtag: assert property (trace_single_en |-> !jtag_en)
    else $error("single wire trace together with jtag");
  a_par_all_pins: assert property (|trace_par_oe |-> &trace_par_oe && !trace_single_en)
    else $error("parallel trace pins not driven together");
  a_clk_third: assert property ($rose(lclk[0]) |-> s_clk_held)
    else $error("serial clock high phase too short");
endmodule

// File: sdal_tb.sv
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
module sdal_tb;
  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic        acq_start = 1'b0;
  logic        acq_usb   = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [7:0]  cmd_op    = 8'h00;
  logic [31:0] cmd_data  = 32'h0000_0000;
  logic [31:0] lock_latch_nv_q = ~sdal_pkg::LOCK_KEY;
  logic        jtag_swd_on = 1'b0;
  logic        cmd_ready, rsp_valid, lock_latch_prog_req, flash_req, jtag_en;
  logic        swd_on_jtag, swd_on_usb, trace_single_en, locked, acq_window;
  logic [31:0] rsp_data, lock_latch_prog_data, flash_data, rsp;
  logic [1:0]  flash_op;
  logic [4:0]  trace_par_oe;
  int          errors = 0;
  int          cmp_count = 0;
  int          flash_cnt = 0;

  sdal_link_if link ();

  always #5 clk = ~clk;

  sdal_host i_sdal_host (.clk(clk), .rst_n(rst_n), .link(link), .acq_start(acq_start),
    .acq_usb(acq_usb), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));

  sdal_device i_sdal_device (.clk(clk), .rst_n(rst_n), .link(link),
    .lock_latch_nv_q(lock_latch_nv_q), .jtag_swd_on(jtag_swd_on),
    .lock_latch_prog_req(lock_latch_prog_req), .lock_latch_prog_data(lock_latch_prog_data),
    .flash_req(flash_req), .flash_op(flash_op),
    .flash_data(flash_data), .jtag_en(jtag_en), .swd_on_jtag(swd_on_jtag),
    .swd_on_usb(swd_on_usb), .trace_single_en(trace_single_en),
    .trace_par_oe(trace_par_oe), .locked(locked), .acq_window(acq_window));

  sdal_props i_sdal_props (.clk(clk), .rst_n(rst_n), .lclk(link.clk), .d_oe(link.d_oe),
    .swd_on_jtag(swd_on_jtag), .swd_on_usb(swd_on_usb), .jtag_en(jtag_en),
    .locked(locked), .acq_window(acq_window), .trace_single_en(trace_single_en),
    .trace_par_oe(trace_par_oe), .flash_req(flash_req));

  // Nonvolatile cells take the key when programmed
  always @(posedge clk) begin
    if (lock_latch_prog_req) lock_latch_nv_q <= lock_latch_prog_data;
    if (flash_req) flash_cnt <= flash_cnt + 1;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
  endtask

  task automatic cmd(input logic [7:0] op, input logic [31:0] dat);
    int n;
    n = 0;
    cmd_op = op;
    cmd_data = dat;
    chk("cmd_ready", 32'h0000_0001, 32'(cmd_ready));
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk("cmd_ready busy", 32'h0000_0000, 32'(cmd_ready));
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk("rsp_valid", 32'h0000_0001, 32'(n < 4000));
    rsp = rsp_data;
  endtask

  task automatic acc(input logic a);
    chk("accepted", 32'(a), 32'(rsp[0]));
  endtask

  // Acquisition of 16 bits needs about 260 cycles at the host's rate
  task automatic acquire(input logic usb);
    acq_usb = usb;
    acq_start = 1'b1;
    @(negedge clk);
    acq_start = 1'b0;
    repeat (400) @(negedge clk);
  endtask

  task automatic t_usb_session();
    do_reset();
    acquire(1'b1);
    chk("swd_on_usb", 32'h0000_0001, 32'(swd_on_usb));
    chk("swd_on_jtag", 32'h0000_0000, 32'(swd_on_jtag));
    cmd(sdal_pkg::OP_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_000B, rsp);
  endtask

  task automatic t_trace();
    cmd(sdal_pkg::OP_TRACE_CFG, 32'h0000_0001);
    acc(1'b0);
    cmd(sdal_pkg::OP_TRACE_CFG, 32'h0000_0002);
    acc(1'b1);
    chk("trace_par_oe", 32'h0000_001F, 32'(trace_par_oe));
    cmd(sdal_pkg::OP_TRACE_CFG, 32'h0000_0003);
    acc(1'b0);
    cmd(sdal_pkg::OP_TRACE_CFG, 32'h0000_0000);
    chk("trace_par_oe", 32'h0000_0000, 32'(trace_par_oe));
  endtask

  task automatic t_flash_prot();
    int n;
    cmd(sdal_pkg::OP_BLK_PROG, 32'h0000_0003);
    acc(1'b1);
    chk("flash_op", 32'h0000_0002, 32'(flash_op));
    chk("flash_data", 32'h0000_0003, flash_data);
    cmd(sdal_pkg::OP_SET_PROT, 32'h0000_0003);
    n = flash_cnt;
    cmd(sdal_pkg::OP_BLK_ERASE, 32'h0000_0003);
    acc(1'b0);
    chk("flash_cnt", 32'(n), 32'(flash_cnt));
    cmd(sdal_pkg::OP_BLK_ERASE, 32'h0000_0005);
    acc(1'b1);
    chk("flash_op", 32'h0000_0001, 32'(flash_op));
    cmd(sdal_pkg::OP_LATCH_LOAD, sdal_pkg::LOCK_KEY);
    acc(1'b0);
    cmd(sdal_pkg::OP_ERASE_ALL, 32'h0000_0000);
    acc(1'b1);
    chk("flash_op", 32'h0000_0000, 32'(flash_op));
    cmd(sdal_pkg::OP_BLK_VERIFY, 32'h0000_0003);
    acc(1'b1);
    chk("flash_op", 32'h0000_0003, 32'(flash_op));
  endtask

  task automatic t_key_lock();
    cmd(sdal_pkg::OP_LATCH_LOAD, sdal_pkg::LOCK_KEY);
    acc(1'b1);
    cmd(sdal_pkg::OP_LATCH_PROG, 32'h0000_0000);
    chk("lock_latch_nv_q", sdal_pkg::LOCK_KEY, lock_latch_nv_q);
    cmd(sdal_pkg::OP_LATCH_READ, 32'h0000_0000);
    chk("latch_read", sdal_pkg::LOCK_KEY, rsp);
    cmd(sdal_pkg::OP_STATUS, 32'h0000_0000);
    acc(1'b1);
    chk("locked", 32'h0000_0000, 32'(locked));
    do_reset();
    repeat (2) @(negedge clk);
    chk("locked", 32'h0000_0001, 32'(locked));
    chk("jtag_en", 32'h0000_0000, 32'(jtag_en));
    chk("acq_window locked", 32'h0000_0000, 32'(acq_window));
    acquire(1'b1);
    chk("swd_on_usb", 32'h0000_0000, 32'(swd_on_usb));
  endtask

  task automatic t_majority();
    lock_latch_nv_q = sdal_pkg::LOCK_KEY ^ 32'h0000_000F;
    do_reset();
    repeat (2) @(negedge clk);
    chk("locked 28", 32'h0000_0001, 32'(locked));
    lock_latch_nv_q = sdal_pkg::LOCK_KEY ^ 32'h0000_001F;
    do_reset();
    repeat (2) @(negedge clk);
    chk("locked 27", 32'h0000_0000, 32'(locked));
  endtask

  task automatic t_jtag_pair();
    repeat (900) @(negedge clk);
    chk("acq_window late", 32'h0000_0000, 32'(acq_window));
    acquire(1'b0);
    chk("late acquire", 32'h0000_0000, 32'(swd_on_jtag));
    do_reset();
    acquire(1'b0);
    chk("swd_on_jtag", 32'h0000_0001, 32'(swd_on_jtag));
    chk("acq_window", 32'h0000_0001, 32'(acq_window));
    chk("jtag_en", 32'h0000_0000, 32'(jtag_en));
    cmd(sdal_pkg::OP_TRACE_CFG, 32'h0000_0001);
    acc(1'b1);
    chk("trace_single_en", 32'h0000_0001, 32'(trace_single_en));
    cmd(sdal_pkg::OP_JTAG_EN, 32'h0000_0000);
    acc(1'b0);
    cmd(sdal_pkg::OP_TRACE_CFG, 32'h0000_0000);
    cmd(sdal_pkg::OP_JTAG_EN, 32'h0000_0000);
    acc(1'b1);
    chk("jtag_en", 32'h0000_0001, 32'(jtag_en));
    cmd(sdal_pkg::OP_SWD_OFF, 32'h0000_0000);
    repeat (50) @(negedge clk);
    chk("swd off", 32'h0000_0000, 32'(swd_on_jtag));
    jtag_swd_on = 1'b1;
    @(negedge clk);
    jtag_swd_on = 1'b0;
    repeat (2) @(negedge clk);
    chk("swd from jtag", 32'h0000_0001, 32'(swd_on_jtag));
  endtask

  task automatic final_report();
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // About twenty frames of some 1200 cycles each, with margin
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    final_report();
  end

  initial begin
    t_usb_session();
    t_trace();
    t_flash_prot();
    t_key_lock();
    t_majority();
    t_jtag_pair();
    final_report();
  end
endmodule
